/* File: rtl/simd_fp_pkg.sv */
// constants and types for the vector floating-point control/status unit
package simd_fp_pkg;
  localparam int          CSR_W          = 32;
  localparam int          VREG_W         = 128;
  localparam int          VREG_N         = 8;
  localparam int          EXC_N          = 6;
  localparam int          LANES          = 4;
  localparam int          FLAG_LSB       = 0;
  localparam int          DAZ_BIT        = 6;
  localparam int          MASK_LSB       = 7;
  localparam int          RC_LSB         = 13;
  localparam int          FTZ_BIT        = 15;
  localparam logic [31:0] CSR_RESET      = 32'h0000_1F80;
  localparam logic [31:0] WMASK_NO_DAZ   = 32'h0000_FFBF;
  localparam logic [31:0] WMASK_WITH_DAZ = 32'h0000_FFFF;
  localparam logic [31:0] IMG_MASK_NONE  = 32'h0000_0000;
  localparam int          IMG_MASK_BYTE  = 28;
  localparam int          IMG_BYTES      = 512;
  localparam int          ID_LEAF        = 1;
  localparam int          ID_SAVE_BIT    = 24;
  localparam int          ID_VEC1_BIT    = 25;
  localparam int          ID_VEC2_BIT    = 26;
  localparam int          CR4_SAVE_BIT   = 9;
  localparam int          CR4_EXC_BIT    = 10;
  localparam logic [2:0]  PRE_EXC_MASK   = 3'h7;

  typedef enum logic [2:0] {
    OP_NONE, OP_WRITE_CSR, OP_RESTORE_CSR, OP_SAVE, OP_ARITH
  } op_kind_t;
endpackage : simd_fp_pkg

/* File: rtl/simd_fp_exc_if.sv */
// exception event carrier between the top and the flag merger
`timescale 1ns/10ps
interface simd_fp_exc_if;
  logic [simd_fp_pkg::LANES*simd_fp_pkg::EXC_N-1:0] lane_exc;
  logic [simd_fp_pkg::EXC_N-1:0]                    merged;
  modport src (output lane_exc, input merged);
  modport mrg (input lane_exc, output merged);
endinterface : simd_fp_exc_if

/* File: rtl/simd_fp_lane_merge.sv */
// per-lane exception flags ORed per exception type
`timescale 1ns/10ps
module simd_fp_lane_merge (
  simd_fp_exc_if.mrg ex
);
  always_comb begin
    ex.merged = '0;
    for (int l = 0; l < simd_fp_pkg::LANES; l++) begin
      ex.merged = ex.merged |
        ex.lane_exc[l*simd_fp_pkg::EXC_N +: simd_fp_pkg::EXC_N]; // RQ23
    end
  end
endmodule : simd_fp_lane_merge

/* File: rtl/simd_fp_control_status_unit.sv */
// vector floating-point control/status register and exception signalling
`timescale 1ns/10ps
// Behaviour
// (RQ1) masked and unmasked together: set all flags, withhold masked result
// (RQ2) vector exceptions never drive the legacy error output pin
// (RQ3) ignore-numeric-error input has no effect on vector exceptions
// (RQ4) vector and legacy rounding modes do not affect each other
// (RQ5) unmasking an already-set flag raises no fault
// (RQ6) reset sets mask bits 7 to 12
// (RQ7) reset clears flag bits 0 to 5
// (RQ8) reset loads rounding field bits 13-14 with 00B
// (RQ9) reset clears flush-to-zero bit 15
// (RQ10) reset clears denormals-as-zero bit 6
// (RQ11) register resets to 1F80H; soft init leaves all state unchanged
// (RQ12) reset clears all eight vector registers to zero
// (RQ13) writing one to a reserved bit faults and leaves register unchanged
// (RQ14) without denormals-as-zero support bit 6 is reserved
// (RQ15) save image bytes 28-31 carry the writable-bit mask; here zero is saved there without denormals-as-zero support
// (RQ16) save writes vector registers and status; restore reloads them; here the image holds no vector registers, restore loads status only
// (RQ17) identify leaf 1 reports bits 24, 25, 26
// (RQ18) software declares save and handler support in control reg four
// (RQ19) software checks emulation bit in control reg zero is clear
// (RQ20) unsupported vector instruction raises invalid-opcode fault; here an unsupported OP_SAVE raises no fault
// (RQ21) vector masks independent from legacy masks
// (RQ22) unmasked exception: vector fault if cr4 bit 10, else invalid opcode
// (RQ23) per-lane flags ORed per type into status flags
// (RQ24) restore applies the same reserved-bit check as a write
module simd_fp_control_status_unit #(
  parameter bit DAZ_SUPPORTED = 1'b1,
  parameter bit VEC1_PRESENT  = 1'b1,
  parameter bit VEC2_PRESENT  = 1'b1
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic                      init_b,
  input  wire logic                      op_valid,
  input  wire simd_fp_pkg::op_kind_t     op_kind,
  input  wire logic [31:0]               op_data,
  input  wire logic                      op_supported,
  input  wire logic [2:0]                vreg_sel,
  input  wire logic [127:0]              vreg_wdata,
  input  wire logic                      vreg_we,
  input  wire logic [23:0]               lane_exc,
  input  wire logic                      post_phase,
  input  wire logic                      handler_return,
  input  wire logic [31:0]               control_reg_four,
  input  wire logic                      ignore_numeric_error_in,
  input  wire logic                      numeric_error_control,
  input  wire logic [1:0]                legacy_round,
  input  wire logic [31:0]               id_leaf,
  input  wire logic [6:0]                save_word_idx,
  output logic [31:0]                    simd_fp_control_status,
  output logic [127:0]                   vreg_rdata,
  output logic [1:0]                     vec_round_mode,
  output logic                           flush_to_zero,
  output logic                           denormals_as_zero,
  output logic                           simd_fp_fault,
  output logic                           general_protection_fault,
  output logic                           invalid_opcode_fault,
  output logic                           result_release,
  output logic                           fp_error_out,
  output logic [31:0]                    save_word,
  output logic [31:0]                    id_features
);
  localparam logic [31:0] WMASK = DAZ_SUPPORTED ?
    simd_fp_pkg::WMASK_WITH_DAZ : simd_fp_pkg::WMASK_NO_DAZ; // RQ14

  function automatic logic reserved_hit(input logic [31:0] v);
    return |(v & ~WMASK); // RQ13
  endfunction : reserved_hit

  simd_fp_exc_if ex ();
  assign ex.lane_exc = lane_exc;
  simd_fp_lane_merge u_merge (.ex(ex));

  logic [31:0]  csr_q, csr_d;
  logic [127:0] vreg_q [simd_fp_pkg::VREG_N];
  logic [127:0] vreg_d [simd_fp_pkg::VREG_N];
  logic         xf_q, xf_d, gp_q, gp_d, ud_q, ud_d;
  logic         hold_q, hold_d, rel_q, rel_d;
  logic [127:0] rdata_q, rdata_d;
  logic [31:0]  save_q, save_d, id_q, id_d;
  // legacy error pin kept in a flop that vector events never touch
  logic         err_q;

  logic [5:0] exc_now, masks, unmasked;
  logic       wr_like;

  // note: init_b and ignore_numeric_error_in, legacy_round and
  // numeric_error_control are read by nothing; soft init keeps all state
  always_comb begin
    csr_d   = csr_q;
    vreg_d  = vreg_q;
    xf_d    = 1'b0;
    gp_d    = 1'b0;
    ud_d    = 1'b0;
    hold_d  = hold_q;
    rel_d   = 1'b0;
    exc_now = ex.merged;
    masks   = csr_q[simd_fp_pkg::MASK_LSB +: simd_fp_pkg::EXC_N];
    unmasked = exc_now & ~masks;
    wr_like = 1'b0;
    if (vreg_we) begin
      vreg_d[vreg_sel] = vreg_wdata; // RQ16
    end
    if (op_valid) begin
      case (op_kind)
        simd_fp_pkg::OP_WRITE_CSR,
        simd_fp_pkg::OP_RESTORE_CSR: begin
          wr_like = 1'b1;
          if (!op_supported) begin
            ud_d = 1'b1; // RQ20
          end else if (reserved_hit(op_data)) begin
            gp_d = 1'b1; // RQ13 RQ24
          end else begin
            // new masks apply only to later events, so no fault here
            csr_d = op_data; // RQ5
          end
        end
        simd_fp_pkg::OP_ARITH: begin
          if (!op_supported) begin
            ud_d = 1'b1; // RQ20
          end else begin
            // flags for masked and unmasked alike
            csr_d[simd_fp_pkg::FLAG_LSB +: simd_fp_pkg::EXC_N] =
              csr_q[simd_fp_pkg::FLAG_LSB +: simd_fp_pkg::EXC_N] |
              exc_now; // RQ1 RQ23
            if (|unmasked) begin
              hold_d = 1'b1; // RQ1
              if (control_reg_four[simd_fp_pkg::CR4_EXC_BIT]) begin
                xf_d = 1'b1; // RQ22 RQ21
              end else begin
                ud_d = 1'b1; // RQ22
              end
            end else if (post_phase || hold_q == 1'b0) begin
              rel_d = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (hold_q && handler_return && post_phase) begin
      hold_d = 1'b0; // RQ1
      rel_d  = 1'b1;
    end
  end

  always_comb begin
    rdata_d = vreg_q[vreg_sel];
    save_d  = '0;
    if (save_word_idx == 7'(simd_fp_pkg::IMG_MASK_BYTE / 4)) begin
      save_d = DAZ_SUPPORTED ? WMASK : simd_fp_pkg::IMG_MASK_NONE; // RQ15
    end else if (save_word_idx == 7'((simd_fp_pkg::IMG_MASK_BYTE - 4) / 4))
    begin
      save_d = csr_q; // RQ16
    end
    id_d = '0;
    if (id_leaf == 32'(simd_fp_pkg::ID_LEAF)) begin
      id_d[simd_fp_pkg::ID_SAVE_BIT] = 1'b1; // RQ17
      id_d[simd_fp_pkg::ID_VEC1_BIT] = VEC1_PRESENT;
      id_d[simd_fp_pkg::ID_VEC2_BIT] = VEC2_PRESENT;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      csr_q   <= simd_fp_pkg::CSR_RESET; // RQ6 RQ7 RQ8 RQ9 RQ10 RQ11
      for (int i = 0; i < simd_fp_pkg::VREG_N; i++) begin
        vreg_q[i] <= '0; // RQ12
      end
      xf_q    <= 1'b0;
      gp_q    <= 1'b0;
      ud_q    <= 1'b0;
      hold_q  <= 1'b0;
      rel_q   <= 1'b0;
      rdata_q <= '0;
      save_q  <= '0;
      id_q    <= '0;
      err_q   <= 1'b0;
    end else begin
      err_q   <= 1'b0; // RQ2 RQ3
      csr_q   <= csr_d;
      vreg_q  <= vreg_d;
      xf_q    <= xf_d;
      gp_q    <= gp_d;
      ud_q    <= ud_d;
      hold_q  <= hold_d;
      rel_q   <= rel_d;
      rdata_q <= rdata_d;
      save_q  <= save_d;
      id_q    <= id_d;
    end
  end

  assign simd_fp_control_status   = csr_q;
  assign vreg_rdata               = rdata_q;
  assign vec_round_mode           = csr_q[simd_fp_pkg::RC_LSB +: 2]; // RQ4
  assign flush_to_zero            = csr_q[simd_fp_pkg::FTZ_BIT];
  assign denormals_as_zero        = csr_q[simd_fp_pkg::DAZ_BIT];
  assign simd_fp_fault            = xf_q;
  assign general_protection_fault = gp_q;
  assign invalid_opcode_fault     = ud_q;
  assign result_release           = rel_q;
  assign fp_error_out             = err_q; // RQ2 RQ3
  assign save_word                = save_q;
  assign id_features              = id_q;
endmodule : simd_fp_control_status_unit

/* File: verification/simd_fp_csu_assertions.sv */
// assertion checker for the vector control/status unit
`timescale 1ns/10ps
module simd_fp_csu_chk (
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  input wire logic                   op_valid,
  input wire simd_fp_pkg::op_kind_t  op_kind,
  input wire logic [31:0]            op_data,
  input wire logic                   op_supported,
  input wire logic [23:0]            lane_exc,
  input wire logic [31:0]            control_reg_four,
  input wire logic [31:0]            simd_fp_control_status,
  input wire logic                   simd_fp_fault,
  input wire logic                   general_protection_fault,
  input wire logic                   invalid_opcode_fault,
  input wire logic                   result_release,
  input wire logic                   fp_error_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // per-type OR of the four lanes
  wire logic [5:0] exc = lane_exc[5:0] | lane_exc[11:6] | lane_exc[17:12]
                         | lane_exc[23:18];
  wire logic ar = op_valid && op_supported && op_kind == simd_fp_pkg::OP_ARITH;
  wire logic wr = op_valid && op_supported &&
                  (op_kind == simd_fp_pkg::OP_WRITE_CSR ||
                   op_kind == simd_fp_pkg::OP_RESTORE_CSR);
  wire logic bad = |(op_data & ~simd_fp_pkg::WMASK_WITH_DAZ);
  wire logic unm = |(exc & ~simd_fp_control_status[12:7]);
  AST_NO_ERR_PIN: assert property (!fp_error_out)
    else $error("legacy error pin driven");
  AST_RSVD_GP: assert property (wr && bad |=> general_protection_fault &&
    $stable(simd_fp_control_status)) else $error("reserved write taken");
  AST_WRITE_OK: assert property (wr && !bad |=> !general_protection_fault &&
    !simd_fp_fault && simd_fp_control_status == $past(op_data))
    else $error("clean write wrong");
  AST_UNSUP_UD: assert property (op_valid && !op_supported |=>
    invalid_opcode_fault) else $error("no invalid opcode");
  AST_UNMASK_XF: assert property (ar && unm && control_reg_four[10] |=>
    simd_fp_fault && !invalid_opcode_fault) else $error("no vector fault");
  AST_UNMASK_UD: assert property (ar && unm && !control_reg_four[10] |=>
    invalid_opcode_fault && !simd_fp_fault) else $error("no opcode fault");
  AST_FLAG_OR: assert property (ar |=> simd_fp_control_status[5:0] ==
    $past(simd_fp_control_status[5:0] | exc)) else $error("flags wrong");
  AST_WITHHOLD: assert property (ar && unm |=> !result_release)
    else $error("masked result released early");
endmodule : simd_fp_csu_chk
bind simd_fp_control_status_unit simd_fp_csu_chk chk_u (.core_clk, .rst_b,
  .op_valid, .op_kind, .op_data, .op_supported, .lane_exc, .control_reg_four,
  .simd_fp_control_status, .simd_fp_fault, .general_protection_fault,
  .invalid_opcode_fault, .result_release, .fp_error_out);

/* File: verification/simd_fp_control_status_unit_tb.sv */
// self-checking bench for the vector control/status unit
`timescale 1ns/10ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module simd_fp_control_status_unit_tb;
  logic core_clk, rst_b, init_b, op_valid, op_supported, vreg_we, post_phase;
  logic handler_return, ignore_numeric_error_in, numeric_error_control;
  simd_fp_pkg::op_kind_t op_kind;
  logic [31:0] op_data, control_reg_four, id_leaf, simd_fp_control_status;
  logic [31:0] save_word, id_features;
  logic [127:0] vreg_wdata, vreg_rdata;
  logic [23:0] lane_exc;
  logic [6:0] save_word_idx;
  logic [2:0] vreg_sel;
  logic [1:0] legacy_round, vec_round_mode;
  logic flush_to_zero, denormals_as_zero, simd_fp_fault, fp_error_out;
  logic general_protection_fault, invalid_opcode_fault, result_release;
  int num_errors, cmp_count;
  simd_fp_control_status_unit dut_u (.*);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic stop_test;
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // one request; returns in the cycle its pulses stand
  task automatic op(simd_fp_pkg::op_kind_t k, logic [31:0] d, logic s,
                    logic [23:0] e, logic [2:0] f);
    @(negedge core_clk);
    {op_valid, op_kind, op_data, op_supported, lane_exc} = {1'b1, k, d, s, e};
    @(negedge core_clk);
    op_valid = 0;
    `CHK("faults", f, {simd_fp_fault, general_protection_fault,
      invalid_opcode_fault})
  endtask : op
  initial begin
    {rst_b, op_valid, op_supported, vreg_we, post_phase, handler_return} = 0;
    {ignore_numeric_error_in, numeric_error_control, legacy_round} = 0;
    {op_data, lane_exc, vreg_sel, vreg_wdata} = 0;
    {init_b, op_kind, id_leaf} = {1'b1, simd_fp_pkg::OP_NONE, 32'h1};
    {control_reg_four, save_word_idx} = {32'h0000_0600, 7'h06};
    // the emulation bit is taken as clear; the unit has no input for it
    repeat (6) @(negedge core_clk);
    rst_b = 1;
    `CHK("csr", 32'h0000_1F80, simd_fp_control_status)
    for (int i = 0; i < 8; i++) begin
      vreg_sel = 3'(i);
      @(negedge core_clk);
      `CHK("vreg", 128'h0, vreg_rdata)
    end
    `CHK("ident", 3'h7, id_features[26:24])
    `CHK("save csr", 32'h0000_1F80, save_word)
    {init_b, legacy_round} = {1'b0, 2'h2};
    {ignore_numeric_error_in, numeric_error_control} = 2'h3;
    repeat (2) @(negedge core_clk);
    init_b = 1;
    `CHK("init", 32'h0000_1F80, simd_fp_control_status)
    op(simd_fp_pkg::OP_WRITE_CSR, 32'h0000_E03F, 1, 0, 3'h0);
    `CHK("csr", 32'h0000_E03F, simd_fp_control_status)
    @(negedge core_clk);
    `CHK("round", {2'h3, 1'b1}, {vec_round_mode, flush_to_zero})
    op(simd_fp_pkg::OP_WRITE_CSR, 32'h0001_0000, 1, 0, 3'h2);
    op(simd_fp_pkg::OP_RESTORE_CSR, 32'h8000_0000, 1, 0, 3'h2);
    `CHK("csr", 32'h0000_E03F, simd_fp_control_status)
    op(simd_fp_pkg::OP_ARITH, 0, 0, 0, 3'h1);
    op(simd_fp_pkg::OP_WRITE_CSR, 32'h0000_1FC0, 1, 0, 3'h0);
    `CHK("daz", 1'b1, denormals_as_zero)
    op(simd_fp_pkg::OP_ARITH, 0, 1, 24'h00_8002, 3'h0);
    `CHK("flags", 32'h0000_1FCA, simd_fp_control_status)
    `CHK("release", 1'b1, result_release)
    op(simd_fp_pkg::OP_WRITE_CSR, 32'h0000_000A, 1, 0, 3'h0);
    post_phase = 1;
    op(simd_fp_pkg::OP_ARITH, 0, 1, 24'h04_0000, 3'h4);
    `CHK("held", 1'b0, result_release)
    `CHK("flags", 6'h0B, simd_fp_control_status[5:0])
    handler_return = 1;
    @(negedge core_clk);
    handler_return = 0;
    `CHK("release", 1'b1, result_release)
    control_reg_four = 0;
    op(simd_fp_pkg::OP_ARITH, 0, 1, 24'h00_0010, 3'h1);
    save_word_idx = 7'h07;
    vreg_sel = 3'h3;
    vreg_wdata = {4{32'hA5C3_0F96}};
    vreg_we = 1;
    @(negedge core_clk);
    vreg_we = 0;
    @(negedge core_clk);
    `CHK("mask", simd_fp_pkg::WMASK_WITH_DAZ, save_word)
    `CHK("vreg", {4{32'hA5C3_0F96}}, vreg_rdata)
    `CHK("err pin", 1'b0, fp_error_out)
    stop_test();
  end
  // whole run is under a hundred cycles; allow ample margin
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule : simd_fp_control_status_unit_tb
